/* File: spiscr_pkg.sv */
package spiscr_pkg;

  localparam int unsigned CLOCK_PERIOD_NS = 100;
  localparam int unsigned SOFT_RESET_NS   = 750;
  // longest time, so round down, but never below one cycle
  localparam int unsigned SOFT_RESET_CYCLES =
    (SOFT_RESET_NS / CLOCK_PERIOD_NS < 1) ? 1 :
    SOFT_RESET_NS / CLOCK_PERIOD_NS;

  localparam int unsigned ADDR_W     = 15;
  localparam int unsigned INSTR_LAST = 15;
  localparam int unsigned BYTE_LAST  = 7;

  localparam logic [14:0] OFS_IFACE_CFG  = 15'h0000;
  localparam logic [14:0] OFS_POWER_MODE = 15'h0002;
  localparam logic [14:0] OFS_DEV_CLASS  = 15'h0003;
  localparam logic [14:0] OFS_PART_ID_LO = 15'h0004;
  localparam logic [14:0] OFS_PART_ID_HI = 15'h0005;
  localparam logic [14:0] OFS_SI_REV     = 15'h0006;

  localparam int unsigned BIT_SOFT_RESET = 7;
  localparam int unsigned BIT_STREAM_DIR = 5;
  localparam int unsigned BIT_FOUR_WIRE  = 4;
  localparam int unsigned BIT_READ       = 15;

  localparam logic       RST_STREAM_DIR = 1'h1;
  localparam logic [1:0] RST_POWER_MODE = 2'h0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_INSTR,
    ST_DATA,
    ST_HALT
  } spiscr_state_t;

  typedef struct packed {
    spiscr_state_t state;
    logic          sclk_q;
    logic [3:0]    cnt;
    logic [15:0]   shreg;
    logic [14:0]   addr;
    logic          rd;
    logic [7:0]    tx;
    logic          sdo;
    logic          sdo_oe;
    logic          stream_dir;
    logic [1:0]    pmode;
    logic [3:0]    rst_cnt;
    logic          soft_rst;
    logic          power_down;
  } spiscr_regs_t;

  localparam spiscr_regs_t REGS_RESET = '{
    state:      ST_IDLE,
    sclk_q:     1'h0,
    cnt:        4'h0,
    shreg:      16'h0000,
    addr:       15'h0000,
    rd:         1'h0,
    tx:         8'h00,
    sdo:        1'h0,
    sdo_oe:     1'h0,
    stream_dir: RST_STREAM_DIR,
    pmode:      RST_POWER_MODE,
    rst_cnt:    4'h0,
    soft_rst:   1'h0,
    power_down: 1'h0
  };

endpackage

/* File: spiscr_regs.sv */
`timescale 1ns/1ps

// How it works
// - writing one to config bit 7 resets the whole device; bit clears itself
// - the soft reset completes within 750 ns of the write
// - config bit 5 picks streaming step: 0 decrements, 1 increments (reset)
// - config bit 4 is read-only and always reads one: four-wire port
// - power mode values 0 and 1 give normal full-power operation
// - power mode values 2 and 3 power down the entire device
// - low-power and fast-resume states of the generic convention are absent
// - class register: low nibble fixed class code, high nibble zero
// - 16-bit part identity over two byte addresses, read-only, fixed
// - 8-bit silicon revision register is read-only and fixed
module spiscr_regs #(
  parameter logic [15:0] PART_IDENTITY_CODE = 16'h5A3C, // arbitrary value
  parameter logic [3:0]  DEVICE_CLASS_CODE  = 4'h9,     // arbitrary value
  parameter logic [7:0]  SILICON_REVISION   = 8'h42,    // arbitrary value
  parameter int unsigned RESET_CYCLES       = spiscr_pkg::SOFT_RESET_CYCLES
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic spi_cs_n,
  input  wire logic spi_sclk,
  input  wire logic spi_sdi,
  output wire logic spi_sdo,
  output wire logic spi_sdo_oe,
  output wire logic device_reset,
  output wire logic power_down,
  output wire logic stream_address_direction
);

  // the reset counter is four bits wide
  if (RESET_CYCLES < 1 || RESET_CYCLES > 15) begin : g_bad_reset_cycles
    $error("RESET_CYCLES must lie in 1..15");
  end

  spiscr_pkg::spiscr_regs_t s_reg;
  spiscr_pkg::spiscr_regs_t s_next;

  logic        rise;
  logic        fall;
  logic        wr_en;
  logic        ld_en;
  logic        byte_done;
  logic [7:0]  wr_data;
  logic [14:0] wr_addr;
  logic [14:0] ld_addr;
  logic [14:0] step_addr;

  function automatic logic [7:0] read_byte(input logic [14:0] a,
                                           input logic        dir,
                                           input logic [1:0]  pm);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      spiscr_pkg::OFS_IFACE_CFG: begin
        v[spiscr_pkg::BIT_STREAM_DIR] = dir;
        v[spiscr_pkg::BIT_FOUR_WIRE]  = 1'b1;
      end
      spiscr_pkg::OFS_POWER_MODE: v[1:0] = pm;
      spiscr_pkg::OFS_DEV_CLASS:  v = {4'h0, DEVICE_CLASS_CODE};
      spiscr_pkg::OFS_PART_ID_LO: v = PART_IDENTITY_CODE[7:0];
      spiscr_pkg::OFS_PART_ID_HI: v = PART_IDENTITY_CODE[15:8];
      spiscr_pkg::OFS_SI_REV:     v = SILICON_REVISION;
      default:                    v = 8'h00;
    endcase
    return v;
  endfunction

  always_comb begin
    s_next    = s_reg;
    rise      = spi_sclk & ~s_reg.sclk_q;
    fall      = ~spi_sclk & s_reg.sclk_q;
    wr_en     = 1'b0;
    ld_en     = 1'b0;
    byte_done = 1'b0;
    wr_data   = {s_reg.shreg[6:0], spi_sdi};
    wr_addr   = s_reg.addr;
    ld_addr   = s_reg.addr;
    step_addr = s_reg.stream_dir ? s_reg.addr + 15'h0001
                                 : s_reg.addr - 15'h0001;
    s_next.sclk_q = spi_sclk;
    // only codes 2 and 3 power down; no other low-power state exists
    s_next.power_down = s_reg.pmode[1];
    if (s_reg.soft_rst) begin
      // port is deaf until the reset ends and the frame closes
      s_next.rst_cnt = s_reg.rst_cnt - 4'h1;
      s_next.state   = spiscr_pkg::ST_HALT;
      s_next.sdo_oe  = 1'b0;
      if (s_reg.rst_cnt == 4'h1) begin
        s_next.soft_rst = 1'b0;
      end
    end else if (spi_cs_n) begin
      s_next.state  = spiscr_pkg::ST_IDLE;
      s_next.sdo_oe = 1'b0;
      s_next.sdo    = 1'b0;
      s_next.cnt    = 4'h0;
    end else begin
      unique case (s_reg.state)
        spiscr_pkg::ST_IDLE: begin
          s_next.state  = spiscr_pkg::ST_INSTR;
          s_next.sdo_oe = 1'b1;
          s_next.cnt    = 4'h0;
        end
        spiscr_pkg::ST_INSTR: begin
          if (rise) begin
            s_next.shreg = {s_reg.shreg[14:0], spi_sdi};
            s_next.cnt   = s_reg.cnt + 4'h1;
            if (s_reg.cnt == 4'(spiscr_pkg::INSTR_LAST)) begin
              s_next.rd    = s_reg.shreg[spiscr_pkg::BIT_READ - 1];
              s_next.addr  = {s_reg.shreg[13:0], spi_sdi};
              s_next.state = spiscr_pkg::ST_DATA;
              s_next.cnt   = 4'h0;
              ld_en        = s_reg.shreg[spiscr_pkg::BIT_READ - 1];
              ld_addr      = {s_reg.shreg[13:0], spi_sdi};
            end
          end
        end
        spiscr_pkg::ST_DATA: begin
          if (rise) begin
            s_next.shreg = {s_reg.shreg[14:0], spi_sdi};
            s_next.cnt   = s_reg.cnt + 4'h1;
            if (s_reg.cnt == 4'(spiscr_pkg::BYTE_LAST)) begin
              byte_done   = 1'b1;
              wr_en       = ~s_reg.rd;
              ld_en       = s_reg.rd;
              ld_addr     = step_addr;
              s_next.addr = step_addr;
              s_next.cnt  = 4'h0;
            end
          end else if (fall && s_reg.rd) begin
            // drive on the falling edge so the host samples on the rising
            s_next.sdo = s_reg.tx[7];
            s_next.tx  = {s_reg.tx[6:0], 1'b0};
          end
        end
        spiscr_pkg::ST_HALT: begin
          s_next.sdo_oe = 1'b0;
        end
      endcase
    end
    if (ld_en) begin
      s_next.tx = read_byte(ld_addr, s_reg.stream_dir, s_reg.pmode);
    end
    if (wr_en) begin
      // read-only and reserved bits are simply not stored
      if (wr_addr == spiscr_pkg::OFS_IFACE_CFG) begin
        if (wr_data[spiscr_pkg::BIT_SOFT_RESET]) begin
          s_next.soft_rst   = 1'b1;
          s_next.rst_cnt    = 4'(RESET_CYCLES);
          s_next.stream_dir = spiscr_pkg::RST_STREAM_DIR;
          s_next.pmode      = spiscr_pkg::RST_POWER_MODE;
          s_next.state      = spiscr_pkg::ST_HALT;
          s_next.sdo_oe     = 1'b0;
        end else begin
          s_next.stream_dir = wr_data[spiscr_pkg::BIT_STREAM_DIR];
        end
      end else if (wr_addr == spiscr_pkg::OFS_POWER_MODE) begin
        s_next.pmode = wr_data[1:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_reg <= spiscr_pkg::REGS_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign spi_sdo                  = s_reg.sdo;
  assign spi_sdo_oe               = s_reg.sdo_oe;
  assign device_reset             = s_reg.soft_rst;
  assign power_down               = s_reg.power_down;
  assign stream_address_direction = s_reg.stream_dir;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // the repeat count matches the default RESET_CYCLES of seven
  sequence s_reset_hold;
    s_reg.soft_rst [*7];
  endsequence

  sequence s_reset_write;
    wr_en && wr_addr == spiscr_pkg::OFS_IFACE_CFG
      && wr_data[spiscr_pkg::BIT_SOFT_RESET];
  endsequence

  a_reset_start: assert property (s_reset_write |=> s_reg.soft_rst
    && s_reg.stream_dir && s_reg.pmode == 2'h0 && !s_reg.sdo_oe)
    else $error("soft reset did not restore the registers");
  a_reset_length: assert property ($rose(s_reg.soft_rst) |->
    s_reset_hold ##1 !s_reg.soft_rst)
    else $error("soft reset did not end after seven cycles");
  a_stream_up: assert property (byte_done && s_reg.stream_dir |=>
    s_reg.addr == 15'($past(s_reg.addr) + 15'h0001))
    else $error("address did not increment");
  a_stream_down: assert property (byte_done && !s_reg.stream_dir |=>
    s_reg.addr == 15'($past(s_reg.addr) - 15'h0001))
    else $error("address did not decrement");
  a_four_wire: assert property (ld_en
    && ld_addr == spiscr_pkg::OFS_IFACE_CFG |=>
    s_reg.tx[spiscr_pkg::BIT_FOUR_WIRE] && !s_reg.tx[7]
    && s_reg.tx[3:0] == 4'h0)
    else $error("config readback wrong");
  a_power_normal: assert property (!s_reg.pmode[1] |=> !s_reg.power_down)
    else $error("normal mode powered down");
  a_power_down: assert property (s_reg.pmode[1] |=> s_reg.power_down)
    else $error("power-down mode not honoured");
  a_class_code: assert property (ld_en
    && ld_addr == spiscr_pkg::OFS_DEV_CLASS |=>
    s_reg.tx == {4'h0, DEVICE_CLASS_CODE})
    else $error("class code wrong");
  a_part_id: assert property (ld_en
    && ld_addr == spiscr_pkg::OFS_PART_ID_HI |=>
    s_reg.tx == PART_IDENTITY_CODE[15:8])
    else $error("part identity high byte wrong");
  a_revision: assert property (ld_en
    && ld_addr == spiscr_pkg::OFS_SI_REV |=> s_reg.tx == SILICON_REVISION)
    else $error("revision code wrong");
  a_ro_ignored: assert property (!(wr_en
    && (wr_addr == spiscr_pkg::OFS_POWER_MODE
    || wr_addr == spiscr_pkg::OFS_IFACE_CFG)) |=> $stable(s_reg.pmode))
    else $error("power mode changed without a write");

endmodule // spiscr_regs

/* File: spiscr_host.sv */
`timescale 1ns/1ps

// serial host, mode 0, msb first; sclk idles low outside frames
module spiscr_host (
  input  wire logic clock,
  output logic      spi_cs_n,
  output logic      spi_sclk,
  output logic      spi_sdi,
  input  wire logic spi_sdo
);
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_sdi  = 1'b0;
  end

  // each sclk level lasts at least two clocks
  task automatic xbyte(input logic [7:0] wd, output logic [7:0] rd);
    for (int i = 7; i >= 0; i--) begin
      spi_sclk <= 1'b0;
      spi_sdi  <= wd[i];
      repeat (3) @(posedge clock);
      spi_sclk <= 1'b1;
      @(posedge clock);
      @(negedge clock);
      rd[i] = spi_sdo;
      @(posedge clock);
    end
  endtask

  task automatic start(input logic [15:0] instr);
    logic [7:0] unused;
    @(posedge clock);
    spi_cs_n <= 1'b0;
    repeat (2) @(posedge clock);
    xbyte(instr[15:8], unused);
    xbyte(instr[7:0], unused);
  endtask

  // idle data line flips so a stale bit is never read as valid
  task automatic stop();
    spi_sclk <= 1'b0;
    spi_sdi  <= ~spi_sdi;
    repeat (2) @(posedge clock);
    spi_cs_n <= 1'b1;
    repeat (3) @(posedge clock);
  endtask
endmodule // spiscr_host

/* File: spiscr_regs_bench.sv */
`timescale 1ns/1ps

module spiscr_regs_bench;
  localparam logic [15:0] ID  = 16'hC3A5; // arbitrary value
  localparam logic [3:0]  CLS = 4'h6;     // arbitrary value
  localparam logic [7:0]  REV = 8'h5D;    // arbitrary value
  logic       clock;
  logic       rst_n;
  wire        cs_n, sclk, sdi, sdo, sdo_oe, dev_rst, pdn, dir;
  int         miscompares = 0;
  int         check_count = 0;
  int         rst_len;
  logic [7:0] a, b, rnd;

  spiscr_regs #(.PART_IDENTITY_CODE(ID), .DEVICE_CLASS_CODE(CLS),
    .SILICON_REVISION(REV)) DUT (.clock(clock), .rst_n(rst_n),
    .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_sdi(sdi), .spi_sdo(sdo),
    .spi_sdo_oe(sdo_oe), .device_reset(dev_rst), .power_down(pdn),
    .stream_address_direction(dir));
  spiscr_host host (.clock(clock), .spi_cs_n(cs_n), .spi_sclk(sclk),
    .spi_sdi(sdi), .spi_sdo(sdo));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // mid-cycle sample, so the count never races the launching edge
  always @(negedge clock) if (dev_rst === 1'b1) rst_len <= rst_len + 1;

  function automatic logic [7:0] cfg_exp(input logic d);
    return {2'b00, d, 1'b1, 4'h0};
  endfunction

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [14:0] ad, input logic [7:0] d);
    logic [7:0] r;
    host.start({1'b0, ad});
    host.xbyte(d, r);
    host.stop();
  endtask

  task automatic rd2(input logic [14:0] ad, output logic [7:0] r0, r1);
    host.start({1'b1, ad});
    check("oe frame", 8'h01, {7'h0, sdo_oe});
    host.xbyte(8'h00, r0);
    host.xbyte(8'h00, r1);
    host.stop();
  endtask

  task automatic ids();
    rd2(spiscr_pkg::OFS_DEV_CLASS, a, b);
    check("class", {4'h0, CLS}, a);
    check("id low", ID[7:0], b);
    rd2(spiscr_pkg::OFS_PART_ID_HI, a, b);
    check("id high", ID[15:8], a);
    check("revision", REV, b);
  endtask

  task automatic soft_reset_test();
    wr(spiscr_pkg::OFS_POWER_MODE, 8'h03);
    rst_len = 0;
    rnd = 8'($urandom);
    host.start({1'b0, spiscr_pkg::OFS_IFACE_CFG});
    // bit 5 cleared here, so only the reset can bring it back
    host.xbyte({3'b100, rnd[4:0]}, a);
    for (int i = 0; i < 30 && dev_rst !== 1'b0; i++) @(posedge clock);
    if (dev_rst !== 1'b0) begin
      miscompares++;
      $display("BAD reset end expected 0 seen %b", dev_rst);
      return;
    end
    check("reset long", 8'h01, {7'h0, rst_len inside {[1:7]}});
    check("oe in reset", 8'h00, {7'h0, sdo_oe});
    host.stop();
    repeat (8) @(posedge clock);
    check("pd after", 8'h00, {7'h0, pdn});
    rd2(spiscr_pkg::OFS_IFACE_CFG, a, b);
    check("cfg after", cfg_exp(1'b1), a);
    rd2(spiscr_pkg::OFS_POWER_MODE, a, b);
    check("mode after", 8'h00, a);
    $display("test soft reset done");
  endtask

  initial begin
    rst_n = 1'b0;
    rst_len = 0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    rnd = 8'($urandom(18));
    check("oe idle", 8'h00, {7'h0, sdo_oe});
    rd2(spiscr_pkg::OFS_IFACE_CFG, a, b);
    check("cfg reset", cfg_exp(1'b1), a);
    check("reserved", 8'h00, b);
    ids();
    $display("test reset values done");
    for (int m = 3; m >= 0; m--) begin
      rnd = 8'($urandom);
      wr(spiscr_pkg::OFS_POWER_MODE, {rnd[7:2], 2'(m)});
      check("power down", {7'h0, m[1]}, {7'h0, pdn});
      rd2(spiscr_pkg::OFS_POWER_MODE, a, b);
      check("mode", {6'h0, 2'(m)}, a);
    end
    $display("test power modes done");
    // every byte but config and power mode is read-only or reserved
    for (int i = 1; i < 7; i++) begin
      if (i != 2) wr(15'(i), 8'($urandom));
    end
    ids();
    $display("test read-only writes done");
    rnd = 8'($urandom);
    wr(spiscr_pkg::OFS_IFACE_CFG, {2'b00, 1'b0, rnd[4:0]});
    check("dir", 8'h00, {7'h0, dir});
    rd2(spiscr_pkg::OFS_PART_ID_HI, a, b);
    check("desc first", ID[15:8], a);
    check("desc next", ID[7:0], b);
    rd2(spiscr_pkg::OFS_IFACE_CFG, a, b);
    check("cfg desc", cfg_exp(1'b0), a);
    $display("test descending stream done");
    soft_reset_test();
    final_report();
  end
endmodule // spiscr_regs_bench
